//--- testbench/pin_partner.sv
// Circuitry on one bidirectional port's pins.
// Assumes pull resistors pull up; bench may drive pins itself.
`timescale 1ns/1ps
module pin_partner (
   // Clock
   input wire logic i_clk,
   // Device side
   input wire qnp_pkg::pin_drv_type i_drv,
   input wire logic i_pull,
   input wire qnp_pkg::hold_type i_hold,
   // Bench side
   input wire logic [3:0] i_ext_oe,
   input wire logic [3:0] i_ext_val,
   // Resolved level
   output logic [3:0] o_pin
);
   import qnp_pkg::*;
   logic flt_q = 1'b0;
   always @(posedge i_clk) flt_q <= ~flt_q;
   always_comb begin
      for (int i = 0; i < 4; i++) begin
         if (i_drv.oe[i]) o_pin[i] = i_drv.o[i];
         else if (i_ext_oe[i]) o_pin[i] = i_ext_val[i];
         else if (i_pull) o_pin[i] = 1'b1;
         else if (i_hold.en[i]) o_pin[i] = i_hold.lvl[i];
         else o_pin[i] = flt_q;
      end
   end
endmodule

//--- testbench/tb_quad_nibble_port_control.sv
// Bench for the nibble port block.
// Assumes pull resistors pulling up; keeper option fitted until the last test.
`timescale 1ns/1ps
module tb_quad_nibble_port_control;
   import qnp_pkg::*;
   logic clk = 1'b0;
   logic rst = 1'b1;
   bidir_ctl_type a_ctl = '0, b_ctl = '0;
   out_ctl_type n_ctl = '0;
   logic [3:0] a_pin, b_pin, a_rd, b_rd, ext_oe = 4'h0, ext_val = 4'h0;
   logic mode = 1'b0, carr = 1'b0, alrm = 1'b0, fit = 1'b1, a_pull, b_pull, ev;
   pin_drv_type a_drv, b_drv, n_drv;
   hold_type a_hold, b_hold;
   int mismatches = 0, checked = 0;
   always #2.5 clk = ~clk;
   quad_nibble_port_control DUT (.I_CLK_SYS(clk), .I_SYS_RST(rst), .I_A_CTL(a_ctl),
      .I_B_CTL(b_ctl), .I_N_CTL(n_ctl), .I_A_PIN(a_pin), .I_B_PIN(b_pin),
      .I_HOLD_FITTED(fit), .I_T2_EVENT_MODE(mode), .I_CARRIER(carr), .I_ALARM(alrm),
      .O_A_DRV(a_drv), .O_B_DRV(b_drv), .O_N_DRV(n_drv), .O_A_PULL(a_pull),
      .O_B_PULL(b_pull), .O_A_HOLD(a_hold), .O_B_HOLD(b_hold), .O_A_RD(a_rd),
      .O_B_RD(b_rd), .O_T2_EVENT_CLK(ev));
   pin_partner pa (.i_clk(clk), .i_drv(a_drv), .i_pull(a_pull), .i_hold(a_hold),
      .i_ext_oe(ext_oe), .i_ext_val(ext_val), .o_pin(a_pin));
   pin_partner pb (.i_clk(clk), .i_drv(b_drv), .i_pull(b_pull), .i_hold(b_hold),
      .i_ext_oe(4'h0), .i_ext_val(4'h0), .o_pin(b_pin));
   task automatic chk(input string nm, input logic [3:0] e, input logic [3:0] g);
      checked++;
      if (g !== e) begin
         mismatches++;
         $display("ERROR %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic wr(input int p, input logic [9:0] f);
      @(posedge clk);
      if (p == 0) a_ctl <= bidir_ctl_type'({1'b1, f});
      else if (p == 1) b_ctl <= bidir_ctl_type'({1'b1, f});
      else n_ctl <= out_ctl_type'({1'b1, f});
      @(posedge clk);
      a_ctl.wr <= 1'b0;
      b_ctl.wr <= 1'b0;
      n_ctl.wr <= 1'b0;
      repeat (2) @(posedge clk);
      #1;
   endtask
   task automatic summarize;
      $display("mismatches %0d checked %0d", mismatches, checked);
      if (mismatches == 0 && checked > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   initial begin
      #3000;
      mismatches++;
      summarize();
   end
   initial begin
      repeat (5) @(posedge clk);
      #1;
      chk("a_pull", 4'h1, {3'h0, a_pull});
      chk("b_pull", 4'h1, {3'h0, b_pull});
      chk("a_hold_en", 4'h0, a_hold.en);
      chk("a_oe", 4'h0, a_drv.oe);
      chk("b_oe", 4'h0, b_drv.oe);
      @(posedge clk);
      rst <= 1'b0;
      repeat (2) @(posedge clk);
      #1;
      chk("a_pull", 4'h0, {3'h0, a_pull});
      chk("b_hold_en", 4'hf, b_hold.en);
      wr(0, {4'h5, 4'hf, 1'b0, 1'b0});
      chk("a_o", 4'h5, a_drv.o);
      chk("a_oe", 4'hf, a_drv.oe);
      chk("a_rd", 4'h5, a_rd);
      wr(0, {4'h5, 4'hf, 1'b1, 1'b1});
      chk("a_o", 4'h0, a_drv.o);
      chk("a_oe", 4'ha, a_drv.oe);
      chk("a_pull", 4'h1, {3'h0, a_pull});
      chk("a_rd", 4'h5, a_rd);
      wr(1, {4'h3, 4'hc, 1'b1, 1'b0});
      chk("b_oe", 4'hc, b_drv.oe);
      chk("b_o", 4'h3, b_drv.o);
      chk("b_rd", 4'h3, b_rd);
      chk("b_pull", 4'h1, {3'h0, b_pull});
      chk("b_hold_en", 4'h3, b_hold.en);
      chk("b_hold_lvl", 4'h3, b_hold.lvl);
      wr(2, {4'hf, 4'h5, 1'b0, 1'b0});
      chk("n_o", 4'ha, n_drv.o);
      chk("n_oe", 4'ha, n_drv.oe);
      @(posedge clk);
      carr <= 1'b1;
      wr(2, {4'h0, 4'h0, 1'b1, 1'b1});
      chk("n_o", 4'h4, n_drv.o);
      @(posedge clk);
      carr <= 1'b0;
      alrm <= 1'b1;
      repeat (3) @(posedge clk);
      #1;
      chk("n_o", 4'h8, n_drv.o);
      @(posedge clk);
      ext_oe <= 4'h8;
      ext_val <= 4'h8;
      mode <= 1'b1;
      wr(0, {4'hf, 4'h0, 1'b0, 1'b0});
      chk("ev", 4'h1, {3'h0, ev});
      chk("a_hold_lvl", 4'h1, {3'h0, a_hold.lvl[3]});
      @(posedge clk);
      mode <= 1'b0;
      repeat (3) @(posedge clk);
      #1;
      chk("ev", 4'h0, {3'h0, ev});
      @(posedge clk);
      fit <= 1'b0;
      repeat (2) @(posedge clk);
      #1;
      chk("a_hold_en", 4'h0, a_hold.en);
      chk("b_hold_en", 4'h0, b_hold.en);
      summarize();
   end
endmodule

//--- verilog/qnp_pkg.sv
// Shared constants and carrier types for the nibble port block.
// Assumes a single system clock and an asynchronous active-high reset.
package qnp_pkg;

   // Reset values
   localparam logic [3:0] LATCH_RST = 4'hf;
   localparam logic [3:0] DIR_RST = 4'h0;
   localparam logic PULL_SW_RST = 1'b0;
   localparam logic PULL_IN_RST = 1'b1;
   localparam logic OD_RST = 1'b0;
   localparam logic [3:0] N_LATCH_RST = 4'h0;
   localparam logic [3:0] N_OD_RST = 4'h0;
   localparam logic N_SEL_RST = 1'b0;

   // Field positions of shared pins
   localparam int EVENT_PIN_BIT = 3;
   localparam int CARRIER_BIT = 2;
   localparam int ALARM_BIT = 3;

   // Control word for one bidirectional port, applied on wr
   typedef struct packed {
      logic wr;
      logic [3:0] latch;
      logic [3:0] dir;
      logic pull_en;
      logic od_sel;
   } bidir_ctl_type;

   // Control word for the output-only port, applied on wr
   typedef struct packed {
      logic wr;
      logic [3:0] latch;
      logic [3:0] od;
      logic carrier_sel;
      logic alarm_sel;
   } out_ctl_type;

   // Pad drive: level and output enable per pin
   typedef struct packed {
      logic [3:0] o;
      logic [3:0] oe;
   } pin_drv_type;

   // Level keeper: enable and held level per pin
   typedef struct packed {
      logic [3:0] en;
      logic [3:0] lvl;
   } hold_type;

endpackage

//--- verilog/quad_nibble_port_control.sv
// Port logic: two 4-bit bidirectional ports, one 4-bit output port.
// Assumes pin levels and control words are synchronous to I_CLK_SYS.
// Summary of operation
// - Pull resistors on during reset, off after release until software enables
// - Level hold inactive during reset, starts at release
// - Reset sets every bidirectional pin to input, latches to all ones
// - One pull enable per bidirectional port covers all four pins
// - One push-pull or open-drain select per bidirectional port
// - Output port selects push-pull or open-drain per pin
// - Timer event mode routes port A pin 4 to the timer clock
// - Output port pin 3 can carry the carrier generator signal
// - Output port pin 4 can carry the alarm pulse signal
// - With hold fitted, each bidirectional pin set as input keeps its present level
`timescale 1ns/1ps

module quad_nibble_port_control (
   // Clock and reset
   input wire logic I_CLK_SYS,
   input wire logic I_SYS_RST,
   // Software control
   input wire qnp_pkg::bidir_ctl_type I_A_CTL,
   input wire qnp_pkg::bidir_ctl_type I_B_CTL,
   input wire qnp_pkg::out_ctl_type I_N_CTL,
   // Pin levels
   input wire logic [3:0] I_A_PIN,
   input wire logic [3:0] I_B_PIN,
   // Options and peripheral sources
   input wire logic I_HOLD_FITTED,
   input wire logic I_T2_EVENT_MODE,
   input wire logic I_CARRIER,
   input wire logic I_ALARM,
   // Pad drive
   output qnp_pkg::pin_drv_type O_A_DRV,
   output qnp_pkg::pin_drv_type O_B_DRV,
   output qnp_pkg::pin_drv_type O_N_DRV,
   // Pull resistors and keepers
   output logic O_A_PULL,
   output logic O_B_PULL,
   output qnp_pkg::hold_type O_A_HOLD,
   output qnp_pkg::hold_type O_B_HOLD,
   // Read data and routed clock
   output logic [3:0] O_A_RD,
   output logic [3:0] O_B_RD,
   output logic O_T2_EVENT_CLK
);
   import qnp_pkg::*;

   // Drive of four pins from latch, direction and open-drain mask
   function automatic pin_drv_type drive(input logic [3:0] latch, input logic [3:0] dir,
                                         input logic [3:0] od);
      pin_drv_type r;
      r.o = latch & ~od;
      r.oe = dir & (~od | ~latch);
      return r;
   endfunction

   bidir_ctl_type ctl [2];
   logic [3:0] latch_q [2];
   logic [3:0] dir_q [2];
   logic pull_q [2];
   logic od_q [2];
   logic [3:0] n_latch_q;
   logic [3:0] n_od_q;
   logic n_car_q;
   logic n_alm_q;
   logic rel_q;

   assign ctl[0] = I_A_CTL;
   assign ctl[1] = I_B_CTL;

   // Selected output port data
   wire logic [3:0] n_val = {n_alm_q ? I_ALARM : n_latch_q[ALARM_BIT],
                             n_car_q ? I_CARRIER : n_latch_q[CARRIER_BIT],
                             n_latch_q[1:0]};
   wire pin_drv_type a_drv = drive(latch_q[0], dir_q[0], {4{od_q[0]}});
   wire pin_drv_type b_drv = drive(latch_q[1], dir_q[1], {4{od_q[1]}});
   wire pin_drv_type n_drv = drive(n_val, 4'hf, n_od_q);
   wire logic [3:0] a_keep = I_HOLD_FITTED ? ~dir_q[0] : 4'h0;
   wire logic [3:0] b_keep = I_HOLD_FITTED ? ~dir_q[1] : 4'h0;

   // Bidirectional port registers
   always_ff @(posedge I_CLK_SYS or posedge I_SYS_RST) begin
      if (I_SYS_RST) begin
         for (int i = 0; i < 2; i++) begin
            latch_q[i] <= LATCH_RST;
            dir_q[i] <= DIR_RST;
            pull_q[i] <= PULL_SW_RST;
            od_q[i] <= OD_RST;
         end
      end else begin
         for (int i = 0; i < 2; i++) begin
            if (ctl[i].wr) begin
               latch_q[i] <= ctl[i].latch;
               dir_q[i] <= ctl[i].dir;
               pull_q[i] <= ctl[i].pull_en;
               od_q[i] <= ctl[i].od_sel;
            end
         end
      end
   end

   // Output port registers
   always_ff @(posedge I_CLK_SYS or posedge I_SYS_RST) begin
      if (I_SYS_RST) begin
         n_latch_q <= N_LATCH_RST;
         n_od_q <= N_OD_RST;
         n_car_q <= N_SEL_RST;
         n_alm_q <= N_SEL_RST;
      end else if (I_N_CTL.wr) begin
         n_latch_q <= I_N_CTL.latch;
         n_od_q <= I_N_CTL.od;
         n_car_q <= I_N_CTL.carrier_sel;
         n_alm_q <= I_N_CTL.alarm_sel;
      end
   end

   // Registered pad outputs
   always_ff @(posedge I_CLK_SYS or posedge I_SYS_RST) begin
      if (I_SYS_RST) begin
         O_A_DRV <= '0;
         O_B_DRV <= '0;
         O_N_DRV <= '0;
         O_A_PULL <= PULL_IN_RST;
         O_B_PULL <= PULL_IN_RST;
         O_A_HOLD <= '0;
         O_B_HOLD <= '0;
         O_A_RD <= 4'h0;
         O_B_RD <= 4'h0;
         O_T2_EVENT_CLK <= 1'b0;
         rel_q <= 1'b0;
      end else begin
         O_A_DRV <= a_drv;
         O_B_DRV <= b_drv;
         O_N_DRV <= n_drv;
         O_A_PULL <= pull_q[0];
         O_B_PULL <= pull_q[1];
         O_A_HOLD <= '{en: a_keep, lvl: I_A_PIN};
         O_B_HOLD <= '{en: b_keep, lvl: I_B_PIN};
         O_A_RD <= I_A_PIN;
         O_B_RD <= I_B_PIN;
         O_T2_EVENT_CLK <= I_T2_EVENT_MODE & I_A_PIN[EVENT_PIN_BIT];
         rel_q <= 1'b1;
      end
   end

   // Checks
   default clocking cb @(posedge I_CLK_SYS);
   endclocking
   default disable iff (I_SYS_RST);

   sequence s_first_edge;
      !rel_q ##1 rel_q;
   endsequence

   a_pull_release: assert property (
      s_first_edge |-> $past(O_A_PULL) && $past(O_B_PULL) && !O_A_PULL && !O_B_PULL)
      else $error("pull enable wrong around reset release");
   a_hold_release: assert property (
      s_first_edge |-> $past(O_A_HOLD.en) == 4'h0 && $past(O_B_HOLD.en) == 4'h0
                       && O_A_HOLD.en == {4{$past(I_HOLD_FITTED)}}
                       && O_B_HOLD.en == {4{$past(I_HOLD_FITTED)}})
      else $error("level hold active during reset or late after release");
   a_reset_state: assert property (
      !rel_q |-> latch_q[0] == 4'hf && latch_q[1] == 4'hf && O_A_DRV.oe == 4'h0
                 && O_B_DRV.oe == 4'h0)
      else $error("bidirectional port not in input mode with latch ones at reset");
   a_pull_write: assert property (
      I_B_CTL.wr |=> ##1 O_B_PULL == $past(I_B_CTL.pull_en, 2))
      else $error("port pull enable did not follow write");
   a_od_release: assert property (
      od_q[0] && dir_q[0][0] && latch_q[0][0] |=> !O_A_DRV.oe[0])
      else $error("open-drain pin driven high");
   a_pp_drive: assert property (
      rel_q && !od_q[1] |=> O_B_DRV.oe == $past(dir_q[1]) && O_B_DRV.o == $past(latch_q[1]))
      else $error("push-pull port does not drive its latch");
   a_n_bit_od: assert property (
      n_od_q[0] && !n_od_q[1] |=> O_N_DRV.oe[1] && O_N_DRV.oe[0] == !$past(n_latch_q[0]))
      else $error("output port per-pin drive type wrong");
   a_event_route: assert property (
      1'b1 |=> O_T2_EVENT_CLK == ($past(I_T2_EVENT_MODE) && $past(I_A_PIN[3])))
      else $error("event clock not routed from port A pin 4");
   a_carrier_out: assert property (
      n_car_q && !n_od_q[2] |=> O_N_DRV.o[2] == $past(I_CARRIER) && O_N_DRV.oe[2])
      else $error("carrier not on output pin 3");
   a_alarm_out: assert property (
      n_alm_q && !n_od_q[3] |=> O_N_DRV.o[3] == $past(I_ALARM) && O_N_DRV.oe[3])
      else $error("alarm not on output pin 4");
   a_hold_keep: assert property (
      rel_q && I_HOLD_FITTED && !dir_q[0][0]
      |=> O_A_HOLD.en[0] && O_A_HOLD.lvl[0] == $past(I_A_PIN[0]))
      else $error("keeper does not hold input pin level");
   a_pull_write_a: assert property (
      I_A_CTL.wr |=> ##1 O_A_PULL == $past(I_A_CTL.pull_en, 2))
      else $error("port A pull enable did not follow write");
   a_latch_load: assert property (
      I_A_CTL.wr |=> latch_q[0] == $past(I_A_CTL.latch) && dir_q[0] == $past(I_A_CTL.dir))
      else $error("port A latch or direction not loaded by write");
   a_pp_port_a: assert property (
      rel_q && !od_q[0] |=> O_A_DRV.oe == $past(dir_q[0]) && O_A_DRV.o == $past(latch_q[0]))
      else $error("port A push-pull drive does not follow latch");
   a_od_port_a: assert property (
      rel_q && od_q[0] |=> O_A_DRV.o == 4'h0
      && O_A_DRV.oe == ($past(dir_q[0]) & ~$past(latch_q[0])))
      else $error("port A open-drain drive wrong");
   a_n_push_pull: assert property (
      rel_q && n_od_q == 4'h0 && !n_car_q && !n_alm_q
      |=> O_N_DRV.oe == 4'hf && O_N_DRV.o == $past(n_latch_q))
      else $error("output port push-pull drive does not follow latch");
   a_n_od_high: assert property (
      rel_q && !n_car_q && !n_alm_q
      |=> (O_N_DRV.o & $past(n_od_q)) == 4'h0
      && (O_N_DRV.oe & $past(n_od_q) & $past(n_latch_q)) == 4'h0)
      else $error("open-drain output pin driven high");
   a_event_idle: assert property (
      rel_q && !I_T2_EVENT_MODE |=> !O_T2_EVENT_CLK)
      else $error("event clock active outside event mode");
   a_keep_port_b: assert property (
      rel_q && I_HOLD_FITTED && !dir_q[1][0]
      |=> O_B_HOLD.en[0] && O_B_HOLD.lvl[0] == $past(I_B_PIN[0]))
      else $error("port B keeper does not hold input pin level");
   a_keep_output_off: assert property (
      rel_q && dir_q[1][3] |=> !O_B_HOLD.en[3])
      else $error("keeper active on an output pin");
   a_keep_unfitted: assert property (
      rel_q && !I_HOLD_FITTED |=> O_A_HOLD.en == 4'h0 && O_B_HOLD.en == 4'h0)
      else $error("keeper active without hold option");

endmodule
